// ===== logic/ssq_sequencer.sv
`timescale 1ns/1ns
// Function
// - Slots advance every 2.0 ms; a slot's supplies switch on when reached.
// - Enable order follows the supply profile strap, open or grounded.
// - Inhibited blocks keep their slot so they can be enabled later.
// - Open profile: usb_ldo only enabled when bus 5 V is present.
// - Grounded profile: boost and usb_ldo always up; usb_ldo fed by boost.
// - Never enable camera, general one/three, video, audio; no boost when open.
// - Mode strap: ground normal, digital usb low-power boot, core test.
// - Chip select sampled at cold start picks SPI or I2C; ignored in I2C.
// - I2C uses SPI clock as SCL and read output as SDA.
// - I2C address low bit comes from the SPI write pin.
// - Sense bits report usb id floating, grounded or factory.
// - OTG boost feedback moves from feedback pin to bus pin.
// - Input path bit connects bus pin to usb regulator input.
// - Inactive touch screen pins route to ADC channels 4 to 7.
// - Touch interrupt mode: weak source on x2, y1 grounded.
// - ADC 7 unscaled or halved, or alternate input on output four.
// - Timing runs from crystal time base, else backup oscillator.
module ssq_sequencer (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             xtal_run_i,
  input  wire logic             xtal_tick_i,
  input  wire logic             turn_on_i,
  input  wire logic             supply_profile_strap_i,
  input  wire ssq_pkg::ssq_lvl_t mode_strap_i,
  input  wire logic             vbus_5v_i,
  input  wire ssq_pkg::ssq_sup_t inhibit_i,
  input  wire ssq_pkg::ssq_sup_t sw_enable_i,
  input  wire ssq_pkg::ssq_uid_t uid_level_i,
  input  wire logic             boost_otg_i,
  input  wire logic             usb_input_path_en_i,
  input  wire logic             touch_active_i,
  input  wire logic             touch_int_mode_i,
  input  wire logic             adc7_div2_i,
  input  wire logic             adc7_alt_i,
  input  wire logic             spi_clk_i,
  input  wire logic             spi_cs_n_i,
  input  wire logic             spi_mosi_i,
  input  wire logic             miso_pin_i,
  input  wire logic             spi_miso_data_i,
  input  wire logic             i2c_sda_low_i,
  output ssq_pkg::ssq_sup_t     supply_en_o,
  output logic                  usb_fed_by_boost_o,
  output logic                  seq_busy_o,
  output logic                  seq_done_o,
  output logic [3:0]            slot_o,
  output logic                  normal_mode_o,
  output logic                  usb_lp_boot_o,
  output logic                  test_mode_o,
  output logic                  port_is_i2c_o,
  output logic                  i2c_addr_bit_o,
  output logic                  uid_float_o,
  output logic                  uid_ground_o,
  output logic                  uid_factory_o,
  output ssq_pkg::ssq_ana_t     ana_o,
  output logic                  core_sclk_o,
  output logic                  core_cs_n_o,
  output logic                  core_mosi_o,
  output logic                  i2c_sda_in_o,
  output logic                  miso_pin_o,
  output logic                  miso_pin_oe_n_o
);
  import ssq_pkg::*;

  localparam logic [SLOT_W-1:0] SLOT_END = SLOT_W'(SLOT_LAST);
  localparam logic [TCNT_W-1:0] TCNT_END = TCNT_W'(SLOT_TICKS - 1);

  typedef struct packed {
    ssq_state_t        st;
    logic [SLOT_W-1:0] slot;
    logic [TCNT_W-1:0] tcnt;
    ssq_sup_t          seq_en;
    logic              prof_gnd;
    ssq_lvl_t          mode;
    logic              i2c;
    logic              addr_bit;
    ssq_uid_t          uid;
    ssq_ana_t          ana;
  } ssq_seq_t;

  ssq_seq_t s_q;
  ssq_seq_t s_d;
  logic     tick;
  logic     slot_end;
  ssq_sup_t slot_mask;

  ssq_tick_gen #(
    .DIV (TB_DIV)
  ) u_tick (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .xtal_run_i  (xtal_run_i),
    .xtal_tick_i (xtal_tick_i),
    .tick_o      (tick)
  );

  // Supplies that belong to a slot in the chosen profile
  function automatic ssq_sup_t slot_table(input logic gnd, input logic [SLOT_W-1:0] sl, input logic vbus);
    ssq_sup_t m;
    m = SUP_NONE;
    if (!gnd) begin
      case (sl)
        4'h0: m.buck_two = 1'b1;
        4'h1: m.buck_four = 1'b1;
        4'h2: m.io_high_ldo = 1'b1;
        4'h3: m.general_ldo_two = 1'b1;
        4'h4: m.buck_one = 1'b1;
        4'h5: m.buck_three = 1'b1;
        4'h6: m.pll_ldo = 1'b1;
        4'h7: m.digital_ldo = 1'b1;
        4'h9: begin
          m.usb_ldo = vbus;
          m.usb_ldo_two = 1'b1;
        end
        default: m = SUP_NONE;
      endcase
    end else begin
      case (sl)
        4'h0: m.buck_two = 1'b1;
        4'h1: m.general_ldo_two = 1'b1;
        4'h2: m.buck_four = 1'b1;
        4'h3: begin
          m.io_high_ldo = 1'b1;
          m.sd_ldo = 1'b1;
        end
        4'h4: begin
          m.boost_supply = 1'b1;
          m.usb_ldo = 1'b1;
        end
        4'h5: m.buck_one = 1'b1;
        4'h6: m.pll_ldo = 1'b1;
        4'h7: m.buck_three = 1'b1;
        4'h8: m.digital_ldo = 1'b1;
        4'h9: m.usb_ldo_two = 1'b1;
        default: m = SUP_NONE;
      endcase
    end
    return m;
  endfunction

  assign slot_end = tick && (s_q.tcnt == TCNT_END);

  always_comb begin
    s_d = s_q;
    // Inhibited blocks lose the enable but the slot still runs its length
    slot_mask = slot_table(s_q.prof_gnd, s_q.slot, vbus_5v_i) & ~inhibit_i;
    case (s_q.st)
      ST_IDLE: begin
        if (turn_on_i) begin
          s_d.st = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // Straps caught once per turn-on, before slot zero
        s_d.prof_gnd = !supply_profile_strap_i;
        s_d.mode = mode_strap_i;
        s_d.i2c = spi_cs_n_i;
        s_d.addr_bit = spi_mosi_i;
        s_d.slot = SLOT_RST;
        s_d.tcnt = TCNT_RST;
        s_d.seq_en = SUP_NONE;
        s_d.st = ST_RUN;
      end
      ST_RUN: begin
        s_d.seq_en = s_q.seq_en | slot_mask;
        if (tick) begin
          s_d.tcnt = s_q.tcnt + TCNT_W'(1);
        end
        if (slot_end) begin
          s_d.tcnt = TCNT_RST;
          if (s_q.slot == SLOT_END) begin
            s_d.st = ST_DONE;
          end else begin
            s_d.slot = s_q.slot + SLOT_W'(1);
          end
        end
      end
      ST_DONE: begin
        if (turn_on_i) begin
          s_d.st = ST_SAMPLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Never-list blocked even if the table were wrong
    s_d.seq_en.camera_ldo = 1'b0;
    s_d.seq_en.general_ldo_one = 1'b0;
    s_d.seq_en.general_ldo_three = 1'b0;
    s_d.seq_en.video_ldo = 1'b0;
    s_d.seq_en.audio_ldo = 1'b0;
    if (!s_d.prof_gnd) begin
      s_d.seq_en.boost_supply = 1'b0;
    end
    s_d.uid = uid_level_i;
    s_d.ana.boost_fb_from_bus = boost_otg_i;
    s_d.ana.bus_to_usb_reg_input = usb_input_path_en_i;
    s_d.ana.touch_to_adc = !touch_active_i;
    s_d.ana.touch_x2_isrc = touch_int_mode_i;
    s_d.ana.touch_y1_gnd = touch_int_mode_i;
    s_d.ana.adc7_div2 = adc7_div2_i && !adc7_alt_i;
    s_d.ana.adc7_alt_src = adc7_alt_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '{st: ST_IDLE, slot: SLOT_RST, tcnt: TCNT_RST, seq_en: SUP_NONE,
               prof_gnd: 1'b0, mode: LVL_GND, i2c: 1'b0, addr_bit: 1'b0,
               uid: UID_FLOAT, ana: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Software may still raise a supply later, including inhibited ones
  assign supply_en_o = s_q.seq_en | sw_enable_i;
  assign usb_fed_by_boost_o = s_q.prof_gnd;
  assign seq_busy_o = (s_q.st == ST_RUN) || (s_q.st == ST_SAMPLE);
  assign seq_done_o = (s_q.st == ST_DONE);
  assign slot_o = s_q.slot;
  assign normal_mode_o = (s_q.mode == LVL_GND);
  assign usb_lp_boot_o = (s_q.mode == LVL_DIG);
  assign test_mode_o = (s_q.mode == LVL_CORE);
  assign port_is_i2c_o = s_q.i2c;
  assign i2c_addr_bit_o = s_q.addr_bit;
  assign uid_float_o = (s_q.uid == UID_FLOAT);
  assign uid_ground_o = (s_q.uid == UID_GROUND);
  assign uid_factory_o = (s_q.uid == UID_FACTORY);
  assign ana_o = s_q.ana;

  // Pin sharing between SPI and I2C
  assign core_sclk_o = spi_clk_i;
  assign core_cs_n_o = s_q.i2c ? 1'b1 : spi_cs_n_i;
  assign core_mosi_o = s_q.i2c ? 1'b0 : spi_mosi_i;
  assign i2c_sda_in_o = s_q.i2c ? miso_pin_i : 1'b1;
  assign miso_pin_o = s_q.i2c ? 1'b0 : spi_miso_data_i;
  // Open drain in I2C: only ever pulls low
  assign miso_pin_oe_n_o = s_q.i2c ? !i2c_sda_low_i : spi_cs_n_i;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_never_list_off: assert property (
    !(s_q.seq_en.camera_ldo | s_q.seq_en.general_ldo_one | s_q.seq_en.general_ldo_three
      | s_q.seq_en.video_ldo | s_q.seq_en.audio_ldo))
    else $error("sequencer enabled a never-list supply");

  a_open_no_boost: assert property (!s_q.prof_gnd |-> !s_q.seq_en.boost_supply)
    else $error("boost enabled in open profile");

  a_usb_needs_vbus: assert property (
    ($rose(s_q.seq_en.usb_ldo) && !s_q.prof_gnd) |-> $past(vbus_5v_i))
    else $error("usb_ldo enabled without bus supply");

  a_gnd_slot_four: assert property (
    (s_q.st == ST_RUN && s_q.prof_gnd && s_q.slot == 4'h4 && !inhibit_i.boost_supply
     && !inhibit_i.usb_ldo) |=> (s_q.seq_en.boost_supply && s_q.seq_en.usb_ldo))
    else $error("boost and usb_ldo not up in slot four");

  a_slot_step: assert property (
    (s_q.st == ST_RUN && s_q.slot != SLOT_END && slot_end) |=> s_q.slot == $past(s_q.slot) + 4'h1)
    else $error("slot did not step by one");

  a_slot_hold: assert property (
    (s_q.st == ST_RUN && !slot_end) |=> $stable(s_q.slot))
    else $error("slot moved before its interval ended");

  a_start_slot_zero: assert property (
    (s_q.st == ST_SAMPLE) |=> (s_q.st == ST_RUN && s_q.slot == 4'h0 && s_q.tcnt == 7'h00))
    else $error("sequencer did not start at slot zero");

  a_mode_onehot: assert property ($onehot({normal_mode_o, usb_lp_boot_o, test_mode_o}))
    else $error("mode decode not one-hot");

  a_i2c_cs_ignored: assert property (s_q.i2c |-> (core_cs_n_o && miso_pin_o == 1'b0))
    else $error("chip select used in I2C mode");

  a_fb_follows_otg: assert property (boost_otg_i |=> ana_o.boost_fb_from_bus)
    else $error("boost feedback not switched to bus pin");

  a_touch_route: assert property (
    !touch_active_i ##1 !touch_active_i |-> ana_o.touch_to_adc)
    else $error("touch pins not routed to ADC");

  a_open_slot_empty: assert property (
    (s_q.st == ST_RUN && !s_q.prof_gnd && s_q.slot == 4'h8) |=> $stable(s_q.seq_en))
    else $error("open profile switched a supply in the empty slot");

  a_slot_supplies_on: assert property (
    (s_q.st == ST_RUN) |=> ((s_q.seq_en & $past(slot_mask)) == $past(slot_mask)))
    else $error("reached slot did not switch its supplies on");

  a_enables_sticky: assert property (
    (s_q.st == ST_RUN) |=> ((s_q.seq_en | $past(s_q.seq_en)) == s_q.seq_en))
    else $error("sequencer dropped an enable during the run");

  a_tick_count_bound: assert property (s_q.tcnt <= TCNT_END)
    else $error("slot tick count ran past its end");

  a_run_holds_state: assert property ((s_q.st == ST_RUN && !slot_end) |=> (s_q.st == ST_RUN))
    else $error("sequencer left the run before a slot ended");

  a_run_ends_done: assert property (
    (s_q.st == ST_RUN && s_q.slot == SLOT_END && slot_end) |=> seq_done_o)
    else $error("sequencer did not finish after the last slot");

  a_profile_feed: assert property (
    (s_q.st == ST_SAMPLE) |=> (usb_fed_by_boost_o == !$past(supply_profile_strap_i)))
    else $error("usb_ldo feed does not follow the supply profile");

  a_mode_capture: assert property (
    (s_q.st == ST_SAMPLE && mode_strap_i == LVL_DIG) |=> usb_lp_boot_o)
    else $error("low-power boot level not decoded");

  a_port_capture: assert property ((s_q.st == ST_SAMPLE) |=> (port_is_i2c_o == $past(spi_cs_n_i)))
    else $error("port kind not taken from chip select");

  a_port_held: assert property ((s_q.st != ST_SAMPLE) |=> $stable(port_is_i2c_o))
    else $error("port kind changed outside turn-on");

  a_scl_pin_map: assert property (s_q.i2c |-> (core_sclk_o == spi_clk_i))
    else $error("serial clock pin not used as bus clock");

  a_sda_pin_map: assert property (s_q.i2c |-> (i2c_sda_in_o == miso_pin_i))
    else $error("read pin not used as bus data");

  a_sda_open_drain: assert property (s_q.i2c |-> (miso_pin_oe_n_o == !i2c_sda_low_i))
    else $error("bus data not driven as open drain");

  a_addr_capture: assert property ((s_q.st == ST_SAMPLE) |=> (i2c_addr_bit_o == $past(spi_mosi_i)))
    else $error("address bit not taken from write pin");

  a_uid_ground: assert property (
    (uid_level_i == UID_GROUND) |=> (uid_ground_o && !uid_float_o && !uid_factory_o))
    else $error("grounded usb id not reported");

  a_uid_factory: assert property (
    (uid_level_i == UID_FACTORY) |=> (uid_factory_o && !uid_float_o && !uid_ground_o))
    else $error("factory usb id not reported");

  a_path_off: assert property (!usb_input_path_en_i |=> !ana_o.bus_to_usb_reg_input)
    else $error("bus pin still switched to usb regulator input");

  a_touch_int_bias: assert property (touch_int_mode_i |=> (ana_o.touch_x2_isrc && ana_o.touch_y1_gnd))
    else $error("touch interrupt bias not applied");

  a_adc7_source: assert property (adc7_alt_i |=> (ana_o.adc7_alt_src && !ana_o.adc7_div2))
    else $error("alternate channel seven input not selected");
endmodule

// ===== logic/ssq_pkg.sv
package ssq_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned TB_HZ       = 32_768;
  localparam int unsigned TB_DIV      = CLK_HZ / TB_HZ;
  localparam int unsigned SLOT_US     = 2_000;
  localparam int unsigned SLOT_TICKS  = (SLOT_US * TB_HZ + 999_999) / 1_000_000;
  localparam int unsigned SLOT_LAST   = 9;
  localparam int unsigned SLOT_W      = 4;
  localparam int unsigned TCNT_W      = 7;
  localparam logic [3:0]  SLOT_RST    = 4'h0;
  localparam logic [6:0]  TCNT_RST    = 7'h00;

  // Supplies the sequencer or software can switch
  typedef struct packed {
    logic audio_ldo;
    logic video_ldo;
    logic general_ldo_three;
    logic general_ldo_one;
    logic camera_ldo;
    logic sd_ldo;
    logic boost_supply;
    logic usb_ldo_two;
    logic usb_ldo;
    logic digital_ldo;
    logic pll_ldo;
    logic general_ldo_two;
    logic io_high_ldo;
    logic buck_four;
    logic buck_three;
    logic buck_two;
    logic buck_one;
  } ssq_sup_t;

  localparam ssq_sup_t SUP_NONE = '0;

  typedef enum logic [1:0] {
    LVL_GND  = 2'h0,
    LVL_DIG  = 2'h1,
    LVL_CORE = 2'h2
  } ssq_lvl_t;

  typedef enum logic [1:0] {
    UID_FLOAT   = 2'h0,
    UID_GROUND  = 2'h1,
    UID_RES     = 2'h2,
    UID_FACTORY = 2'h3
  } ssq_uid_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_RUN    = 4'h4,
    ST_DONE   = 4'h8
  } ssq_state_t;

  // Analog switch settings driven by this block
  typedef struct packed {
    logic boost_fb_from_bus;
    logic bus_to_usb_reg_input;
    logic touch_to_adc;
    logic touch_x2_isrc;
    logic touch_y1_gnd;
    logic adc7_div2;
    logic adc7_alt_src;
  } ssq_ana_t;
endpackage

// ===== logic/ssq_tick_gen.sv
`timescale 1ns/1ns
module ssq_tick_gen #(
  parameter int unsigned DIV = ssq_pkg::TB_DIV
) (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic xtal_run_i,
  input  wire logic xtal_tick_i,
  output logic      tick_o
);
  import ssq_pkg::*;
  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] DIV_END = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } ssq_tg_t;

  ssq_tg_t s_q;
  ssq_tg_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // Backup oscillator keeps counting so a dead crystal costs no time
    if (s_q.cnt == DIV_END) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
    if (xtal_run_i) begin
      s_d.tick = xtal_tick_i;
    end else begin
      s_d.tick = (s_q.cnt == DIV_END);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

  a_slow_tick: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!xtal_run_i && s_q.cnt == DIV_END) |=> tick_o)
    else $error("backup time base missed its tick");

  a_xtal_tick: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    xtal_run_i |=> (tick_o == $past(xtal_tick_i)))
    else $error("crystal tick not passed through");
endmodule

// ===== tb/ssq_host_model.sv
`timescale 1ns/1ns
module ssq_host_model (
  input  wire logic ref_clk_i,
  input  wire logic i2c_mode_i,
  input  wire logic dev_miso_i,
  input  wire logic dev_miso_oe_n_i,
  output logic      spi_clk_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o,
  output logic      pin_miso_o
);
  logic sda_low_q;
  logic last_q;

  initial begin
    {spi_clk_o, spi_cs_n_o, spi_mosi_o, sda_low_q} = '0;
  end

  // Pull-up in I2C; a released SPI line toggles so a stale value cannot pass
  always_comb begin
    if (i2c_mode_i)
      pin_miso_o = !(sda_low_q || (!dev_miso_oe_n_i && !dev_miso_i));
    else if (!dev_miso_oe_n_i)
      pin_miso_o = dev_miso_i;
    else
      pin_miso_o = !last_q;
  end

  // Unknown start value settles to a toggle after one edge
  always @(posedge ref_clk_i)
    last_q <= (pin_miso_o === 1'b1);

  // Select held low across turn-on for SPI, tied high for I2C
  task automatic strap(input logic i2c, input logic a0);
    spi_cs_n_o = i2c;
    spi_mosi_o = a0;
    spi_clk_o = 1'b0;
    sda_low_q = 1'b0;
  endtask

  task automatic drive(input logic clk, input logic cs_n, input logic mosi, input logic sda_low);
    spi_clk_o = clk;
    sda_low_q = sda_low;
    if (!i2c_mode_i) begin
      spi_cs_n_o = cs_n;
      spi_mosi_o = mosi;
    end
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ssq_pkg::*;
  logic       ref_clk_i, sys_rst_i, xtal_run_i, xtal_tick_i, turn_on_i, supply_profile_strap_i, vbus_5v_i;
  logic       boost_otg_i, usb_input_path_en_i, touch_active_i, touch_int_mode_i, adc7_div2_i, adc7_alt_i;
  logic       spi_clk_i, spi_cs_n_i, spi_mosi_i, miso_pin_i, spi_miso_data_i, i2c_sda_low_i, host_i2c;
  logic       usb_fed_by_boost_o, seq_busy_o, seq_done_o, normal_mode_o, usb_lp_boot_o, test_mode_o;
  logic       port_is_i2c_o, i2c_addr_bit_o, uid_float_o, uid_ground_o, uid_factory_o;
  logic       core_sclk_o, core_cs_n_o, core_mosi_o, i2c_sda_in_o, miso_pin_o, miso_pin_oe_n_o;
  logic [3:0] slot_o;
  ssq_lvl_t   mode_strap_i;
  ssq_sup_t   inhibit_i, sw_enable_i, supply_en_o;
  ssq_uid_t   uid_level_i;
  ssq_ana_t   ana_o;
  int         miscompares = 0;
  int         checks = 0;

  ssq_sequencer i_ssq_sequencer (
    .ref_clk_i, .sys_rst_i, .xtal_run_i, .xtal_tick_i, .turn_on_i, .supply_profile_strap_i, .mode_strap_i,
    .vbus_5v_i, .inhibit_i, .sw_enable_i, .uid_level_i, .boost_otg_i, .usb_input_path_en_i, .touch_active_i,
    .touch_int_mode_i, .adc7_div2_i, .adc7_alt_i, .spi_clk_i, .spi_cs_n_i, .spi_mosi_i, .miso_pin_i,
    .spi_miso_data_i, .i2c_sda_low_i, .supply_en_o, .usb_fed_by_boost_o, .seq_busy_o, .seq_done_o, .slot_o,
    .normal_mode_o, .usb_lp_boot_o, .test_mode_o, .port_is_i2c_o, .i2c_addr_bit_o, .uid_float_o,
    .uid_ground_o, .uid_factory_o, .ana_o, .core_sclk_o, .core_cs_n_o, .core_mosi_o, .i2c_sda_in_o,
    .miso_pin_o, .miso_pin_oe_n_o);

  ssq_host_model i_ssq_host_model (.ref_clk_i, .i2c_mode_i(host_i2c), .dev_miso_i(miso_pin_o),
    .dev_miso_oe_n_i(miso_pin_oe_n_o), .spi_clk_o(spi_clk_i), .spi_cs_n_o(spi_cs_n_i), .spi_mosi_o(spi_mosi_i),
    .pin_miso_o(miso_pin_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cumulative enables once slot s has been reached
  function automatic ssq_sup_t exp_en(input logic op, input int s, input logic vb, input ssq_sup_t inh);
    ssq_sup_t e;
    e = SUP_NONE;
    for (int i = 0; i <= s; i++) begin
      case (op ? i : i + 16)
        0, 16:   e.buck_two = 1'b1;
        1, 18:   e.buck_four = 1'b1;
        2:       e.io_high_ldo = 1'b1;
        19:      {e.io_high_ldo, e.sd_ldo} = 2'h3;
        3, 17:   e.general_ldo_two = 1'b1;
        4, 21:   e.buck_one = 1'b1;
        5, 23:   e.buck_three = 1'b1;
        6, 22:   e.pll_ldo = 1'b1;
        7, 24:   e.digital_ldo = 1'b1;
        9:       {e.usb_ldo, e.usb_ldo_two} = {vb, 1'b1};
        20:      {e.boost_supply, e.usb_ldo} = 2'h3;
        25:      e.usb_ldo_two = 1'b1;
        default: ;
      endcase
    end
    return ssq_sup_t'(e & ~inh);
  endfunction

  task automatic run_seq(input int r);
    logic     op, vb, a0;
    ssq_sup_t inh;
    int       k, cnt, ps;
    op = r[0];
    vb = r[1];
    a0 = 1'($urandom);
    // Later runs inhibit nothing so every slot really switches its supplies
    inh = r[1] ? SUP_NONE : ssq_sup_t'(17'($urandom & $urandom));
    @(negedge ref_clk_i);
    supply_profile_strap_i = op;
    vbus_5v_i = vb;
    mode_strap_i = ssq_lvl_t'(2'(r % 3));
    inhibit_i = inh;
    host_i2c = 1'($urandom);
    i_ssq_host_model.strap(host_i2c, a0);
    {turn_on_i, xtal_run_i, xtal_tick_i} = 3'h5;
    @(negedge ref_clk_i);
    turn_on_i = 1'b0;
    k = 0;
    cnt = 0;
    ps = 0;
    while (seq_busy_o === 1'b1 && k < 1500) begin
      @(negedge ref_clk_i);
      k++;
      if (k == 300)
        xtal_run_i = 1'b1;
      if (k < 300)
        chk("slot on slow base", 32'h0, 32'(slot_o));
      if (k > 1)
        chk("enables", 32'(exp_en(op, ps, vb, inh)), 32'(supply_en_o));
      if (seq_busy_o === 1'b1 && slot_o != ps) begin
        chk("slot step", ps + 1, 32'(slot_o));
        if (ps > 0)
          chk("slot length", SLOT_TICKS, cnt);
        cnt = 0;
      end
      cnt++;
      ps = int'(slot_o);
    end
    chk("done", 32'h1, 32'(seq_done_o));
    chk("usb fed by boost", 32'(!op), 32'(usb_fed_by_boost_o));
    chk("mode", 32'h4 >> (r % 3), 32'({normal_mode_o, usb_lp_boot_o, test_mode_o}));
    chk("port select", 32'(host_i2c), 32'(port_is_i2c_o));
    chk("address bit", 32'(a0), 32'(i2c_addr_bit_o));
    sw_enable_i = inh;
    #1;
    chk("late enable", 32'(exp_en(op, 9, vb, inh) | inh), 32'(supply_en_o));
    @(negedge ref_clk_i);
    sw_enable_i = SUP_NONE;
    $display("sequence run %0d done", r);
  endtask

  task automatic pin_test;
    logic c, cs, mo, hl;
    for (int n = 0; n < 8; n++) begin
      @(negedge ref_clk_i);
      {c, cs, mo, hl} = 4'($urandom);
      {boost_otg_i, usb_input_path_en_i, touch_active_i, touch_int_mode_i, adc7_div2_i, adc7_alt_i,
       spi_miso_data_i, i2c_sda_low_i} = 8'($urandom);
      uid_level_i = ssq_uid_t'(2'($urandom));
      i_ssq_host_model.drive(c, cs, mo, hl);
      @(negedge ref_clk_i);
      chk("analog", 32'({boost_otg_i, usb_input_path_en_i, !touch_active_i,
          touch_int_mode_i, touch_int_mode_i, adc7_div2_i & !adc7_alt_i, adc7_alt_i}), 32'(ana_o));
      chk("usb id", 32'({uid_level_i == UID_FLOAT, uid_level_i == UID_GROUND,
          uid_level_i == UID_FACTORY}), 32'({uid_float_o, uid_ground_o, uid_factory_o}));
      chk("sclk", 32'(spi_clk_i), 32'(core_sclk_o));
      chk("port pins", 32'(host_i2c ? {2'h2, !(hl | i2c_sda_low_i), !i2c_sda_low_i} :
          {spi_cs_n_i, spi_mosi_i, 1'b1, spi_cs_n_i}), 32'({core_cs_n_o, core_mosi_o, i2c_sda_in_o, miso_pin_oe_n_o}));
      if (!host_i2c && !spi_cs_n_i)
        chk("read pin", 32'(spi_miso_data_i), 32'(miso_pin_i));
    end
    usb_input_path_en_i = 1'b0;
    $display("pin test done");
  endtask

  initial begin
    sys_rst_i = 1'b1;
    {xtal_run_i, xtal_tick_i, turn_on_i, supply_profile_strap_i, vbus_5v_i, boost_otg_i, usb_input_path_en_i,
     touch_active_i, touch_int_mode_i, adc7_div2_i, adc7_alt_i, spi_miso_data_i, i2c_sda_low_i, host_i2c} = '0;
    mode_strap_i = LVL_GND;
    inhibit_i = SUP_NONE;
    sw_enable_i = SUP_NONE;
    uid_level_i = UID_FLOAT;
    void'($urandom(32'h7C20));
    repeat (4) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    chk("reset state", 32'h0, 32'({seq_busy_o, slot_o, supply_en_o}));
    for (int r = 0; r < 4; r++) begin
      run_seq(r);
      pin_test();
    end
    print_verdict();
  end

  // Four runs take about 39 us; this limit only trips on a hang
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule
